// ### core/lane_sync_pkg.sv
// constants shared by the lane status block and its lane tracker
package lane_sync_pkg;

  // lane geometry
  localparam int lane_count_param = 4;
  localparam int cnt_w            = 3;
  localparam int map_w            = 2;
  localparam int cfg_w            = 16;

  // word lock hunt and loss thresholds, in received words
  localparam logic [6:0] good_hdrs_to_lock  = 7'h3f;
  localparam logic [6:0] loss_window_last   = 7'h3f;
  localparam logic [4:0] bad_hdrs_to_lose   = 5'h0f;

  // sync header error report cadence, in pclk cycles, and error count saturation value
  localparam logic [2:0] report_period_last = 3'h6;
  localparam logic [2:0] err_count_max      = 3'h7;

  // apb register byte offsets
  localparam logic [7:0] ctrl_off     = 8'h00;
  localparam logic [7:0] interval_off = 8'h04;
  localparam logic [7:0] status_off   = 8'h08;
  localparam logic [7:0] map_off      = 8'h0c;
  localparam logic [7:0] int_stat_off = 8'h10;
  localparam logic [7:0] int_mask_off = 8'h14;

  // values after reset
  localparam logic              ctrl_enable_rst = 1'b1;
  localparam logic [cfg_w-1:0]  interval_rst    = 16'h3fff;
  localparam logic [7:0]        int_mask_rst    = 8'h00;

  // field positions
  localparam int st_synced_lsb  = 0;
  localparam int st_syncerr_lsb = 4;
  localparam int st_demux_lsb   = 8;
  localparam int st_spacing_lsb = 12;
  localparam int int_loss_lsb   = 0;
  localparam int int_space_lsb  = 4;

endpackage

// ### core/lane_tracker.sv
// per-lane word lock, marker and sync header error tracking
`timescale 1ns/1ps
module lane_tracker (
  // clock and reset
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  // control
  input  wire logic                                enable,
  input  wire logic                                report_tick,
  input  wire logic [lane_sync_pkg::cfg_w-1:0]     interval_cfg,
  // received word indications
  input  wire logic                                word_valid,
  input  wire logic                                hdr_bad,
  input  wire logic                                marker_seen,
  input  wire logic [lane_sync_pkg::map_w-1:0]     marker_id,
  // lane status
  output logic                                     synced,
  output logic                                     sync_err,
  output logic                                     demux_found,
  output logic [lane_sync_pkg::map_w-1:0]          lane_map,
  output logic                                     spacing_error,
  output logic [lane_sync_pkg::cnt_w-1:0]          err_count,
  output logic                                     err_valid
);

  typedef struct packed {
    logic                             locked;
    logic [6:0]                       good_cnt;
    logic [6:0]                       win_cnt;
    logic [4:0]                       bad_cnt;
    logic                             lost;
    logic                             marker_rcvd;
    logic                             demux;
    logic [lane_sync_pkg::map_w-1:0]  map;
    logic [lane_sync_pkg::cfg_w-1:0]  space_cnt;
    logic                             space_err;
    logic                             no_marker;
    logic [lane_sync_pkg::cnt_w-1:0]  acc;
    logic [lane_sync_pkg::cnt_w-1:0]  count;
    logic                             valid;
  } lane_s;

  lane_s s;
  lane_s next_s;

  // saturating add keeps a burst from wrapping the report to a small value
  function automatic logic [lane_sync_pkg::cnt_w-1:0] sat_inc(
    input logic [lane_sync_pkg::cnt_w-1:0] v);
    sat_inc = (v == lane_sync_pkg::err_count_max) ? v : v + 1'b1;
  endfunction

  // next state of the whole lane
  always_comb begin
    next_s       = s;
    next_s.valid = 1'b0;
    next_s.count = '0;
    // errors are banked and reported as increments once per tick
    if (report_tick) begin
      next_s.valid = (s.acc != '0);
      next_s.count = s.acc;
      next_s.acc   = {2'b00, word_valid & hdr_bad};
    end else if (word_valid && hdr_bad) begin
      next_s.acc = sat_inc(s.acc);
    end
    if (word_valid && !s.locked) begin
      // hunt: a run of good headers gains word lock
      next_s.good_cnt = hdr_bad ? 7'h00 : s.good_cnt + 7'h01;
      if (!hdr_bad && s.good_cnt == lane_sync_pkg::good_hdrs_to_lock) begin
        next_s.locked    = 1'b1;
        next_s.lost      = 1'b0;
        next_s.win_cnt   = '0;
        next_s.bad_cnt   = '0;
        next_s.space_cnt = '0;
        next_s.no_marker = 1'b0;
      end
    end else if (word_valid) begin
      next_s.win_cnt = s.win_cnt + 7'h01;
      if (hdr_bad) begin
        next_s.bad_cnt = s.bad_cnt + 5'h01;
      end
      if (s.win_cnt == lane_sync_pkg::loss_window_last) begin
        next_s.win_cnt = '0;
        next_s.bad_cnt = '0;
      end
      // markers: count words between them and check the spacing
      if (marker_seen) begin
        next_s.marker_rcvd = 1'b1;
        next_s.demux       = 1'b1;
        next_s.map         = marker_id;
        next_s.no_marker   = 1'b0;
        next_s.space_cnt   = '0;
        if (s.marker_rcvd) begin
          next_s.space_err = (s.space_cnt != interval_cfg);
        end
      end else begin
        if (s.space_cnt != '1) begin
          next_s.space_cnt = s.space_cnt + 1'b1;
        end
        if (s.space_cnt == interval_cfg) begin
          // expected marker slot passed empty
          if (s.marker_rcvd) begin
            next_s.space_err = 1'b1;
          end else begin
            next_s.no_marker = 1'b1;
          end
        end
      end
      // too many bad headers in one window drops word lock
      if (hdr_bad && s.bad_cnt == lane_sync_pkg::bad_hdrs_to_lose) begin
        next_s.locked      = 1'b0;
        next_s.lost        = 1'b1;
        next_s.good_cnt    = '0;
        next_s.marker_rcvd = 1'b0;
        next_s.demux       = 1'b0;
        next_s.map         = '0;
        next_s.space_err   = 1'b0;
        next_s.no_marker   = 1'b0;
      end
    end
    // disabled receive path holds everything cleared
    if (!enable) begin
      next_s = '0;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from state flops
  assign synced        = s.locked & s.marker_rcvd;
  assign sync_err      = s.lost | s.no_marker;
  assign demux_found   = s.demux;
  assign lane_map      = s.map;
  assign spacing_error = s.space_err;
  assign err_count     = s.count;
  assign err_valid     = s.valid;

  property p_count_qualified;
    @(posedge pclk) disable iff (!presetn)
      (err_count != '0) |-> err_valid;
  endproperty
  a_count_qualified: assert property (p_count_qualified)
    else $error("nonzero error count without valid");

  property p_valid_spacing;
    @(posedge pclk) disable iff (!presetn)
      err_valid |=> !err_valid [*6];
  endproperty
  a_valid_spacing: assert property (p_valid_spacing)
    else $error("error valid repeated within report period");

  property p_synced_has_map;
    @(posedge pclk) disable iff (!presetn)
      synced |-> (demux_found && !sync_err);
  endproperty
  a_synced_has_map: assert property (p_synced_has_map)
    else $error("synced lane without demux or with sync error");

  sequence s_bad_marker;
    s.locked && s.marker_rcvd && word_valid && marker_seen && !hdr_bad
      && (s.space_cnt != interval_cfg) && enable;
  endsequence
  property p_spacing_flag;
    @(posedge pclk) disable iff (!presetn)
      s_bad_marker |=> spacing_error;
  endproperty
  a_spacing_flag: assert property (p_spacing_flag)
    else $error("misplaced marker did not raise spacing error");

  property p_disable_clears;
    @(posedge pclk) disable iff (!presetn)
      !enable |=> (!synced && !sync_err && !err_valid && lane_map == '0);
  endproperty
  a_disable_clears: assert property (p_disable_clears)
    else $error("lane status not cleared while disabled");

endmodule

// ### core/rx_pcs_lane_sync_status.sv
// receive pcs lane status block with apb registers and interrupt
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
module rx_pcs_lane_sync_status (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  input  wire logic [3:0]   pstrb,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // interrupt
  output logic              irq,
  // per-lane received word indications, same clock
  input  wire logic [3:0]   word_valid,
  input  wire logic [3:0]   hdr_bad,
  input  wire logic [3:0]   marker_seen,
  input  wire logic [7:0]   marker_id,
  // sync header error increments
  output logic [11:0]       sh_err_count,
  output logic [3:0]        sh_err_valid,
  // lane status levels
  output logic [3:0]        lane_synced,
  output logic [3:0]        lane_sync_error,
  output logic [3:0]        lane_marker_demux_found,
  output logic [7:0]        pcs_to_physical_lane_map,
  output logic [3:0]        lane_marker_spacing_error
);

  typedef struct packed {
    logic                             enable;
    logic [lane_sync_pkg::cfg_w-1:0]  interval;
    logic [7:0]                       int_stat;
    logic [7:0]                       int_mask;
    logic                             irq;
    logic [31:0]                      rdata;
    logic                             slverr;
    logic [2:0]                       div;
    logic                             tick;
    logic [3:0]                       prev_err;
    logic [3:0]                       prev_space;
  } top_s;

  top_s s;
  top_s next_s;

  logic [7:0]  events;
  logic [7:0]  w1c;
  logic        wr_en;
  logic        setup;

  // an address is mapped if it names one of the six words
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == lane_sync_pkg::ctrl_off)
            || (a == lane_sync_pkg::interval_off)
            || (a == lane_sync_pkg::status_off)
            || (a == lane_sync_pkg::map_off)
            || (a == lane_sync_pkg::int_stat_off)
            || (a == lane_sync_pkg::int_mask_off);
  endfunction

  // read mux, evaluated in the setup phase
  function automatic logic [31:0] read_word(input logic [7:0] a,
                                            input top_s r);
    read_word = 32'h0000_0000;
    case (a)
      lane_sync_pkg::ctrl_off:     read_word[0] = r.enable;
      lane_sync_pkg::interval_off: read_word[15:0] = r.interval;
      lane_sync_pkg::status_off: begin
        read_word[lane_sync_pkg::st_synced_lsb +: 4]  = lane_synced;
        read_word[lane_sync_pkg::st_syncerr_lsb +: 4] = lane_sync_error;
        read_word[lane_sync_pkg::st_demux_lsb +: 4]   =
          lane_marker_demux_found;
        read_word[lane_sync_pkg::st_spacing_lsb +: 4] =
          lane_marker_spacing_error;
      end
      lane_sync_pkg::map_off:      read_word[7:0] = pcs_to_physical_lane_map;
      lane_sync_pkg::int_stat_off: read_word[7:0] = r.int_stat;
      lane_sync_pkg::int_mask_off: read_word[7:0] = r.int_mask;
      default:                     read_word = 32'h0000_0000;
    endcase
  endfunction

  // zero wait state slave: data is prepared during setup
  assign pready = 1'b1;
  assign setup  = psel & ~penable;
  assign wr_en  = psel & penable & pwrite & addr_hit(paddr);

  // interrupt events: onset of lane sync error (lock loss or missing marker) and of marker spacing error
  assign events[lane_sync_pkg::int_loss_lsb +: 4]  =
    lane_sync_error & ~s.prev_err;
  assign events[lane_sync_pkg::int_space_lsb +: 4] =
    lane_marker_spacing_error & ~s.prev_space;
  assign w1c = (wr_en && paddr == lane_sync_pkg::int_stat_off && pstrb[0])
             ? pwdata[7:0] : 8'h00;

  // next state of registers, divider and interrupt
  always_comb begin
    next_s            = s;
    next_s.prev_err   = lane_sync_error;
    next_s.prev_space = lane_marker_spacing_error;
    // report cadence divider, cleared to zero while the lanes are disabled
    next_s.tick = 1'b0;
    if (!s.enable || s.div == lane_sync_pkg::report_period_last) begin
      next_s.div  = '0;
      next_s.tick = s.enable;
    end else begin
      next_s.div = s.div + 3'h1;
    end
    if (setup) begin
      next_s.rdata  = pwrite ? 32'h0000_0000 : read_word(paddr, s);
      next_s.slverr = ~addr_hit(paddr);
    end
    if (wr_en) begin
      case (paddr)
        lane_sync_pkg::ctrl_off: begin
          if (pstrb[0]) begin
            next_s.enable = pwdata[0];
          end
        end
        lane_sync_pkg::interval_off: begin
          if (pstrb[0]) begin
            next_s.interval[7:0] = pwdata[7:0];
          end
          if (pstrb[1]) begin
            next_s.interval[15:8] = pwdata[15:8];
          end
        end
        lane_sync_pkg::int_mask_off: begin
          if (pstrb[0]) begin
            next_s.int_mask = pwdata[7:0];
          end
        end
        default: begin
          next_s.enable = s.enable;
        end
      endcase
    end
    // an event in the clearing cycle survives: set beats clear
    next_s.int_stat = (s.int_stat & ~w1c) | events;
    next_s.irq      = |(next_s.int_stat & next_s.int_mask);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s          <= '0;
      s.enable   <= lane_sync_pkg::ctrl_enable_rst;
      s.interval <= lane_sync_pkg::interval_rst;
      s.int_mask <= lane_sync_pkg::int_mask_rst;
    end else begin
      s <= next_s;
    end
  end

  assign prdata  = s.rdata;
  assign pslverr = s.slverr & psel & penable;
  assign irq     = s.irq;

  // one tracker per pcs lane
  for (genvar i = 0; i < lane_sync_pkg::lane_count_param; i++) begin : g_lane
    lane_tracker u_lane (
      .pclk          (pclk),
      .presetn       (presetn),
      .enable        (s.enable),
      .report_tick   (s.tick),
      .interval_cfg  (s.interval),
      .word_valid    (word_valid[i]),
      .hdr_bad       (hdr_bad[i]),
      .marker_seen   (marker_seen[i]),
      .marker_id     (marker_id[2*i +: 2]),
      .synced        (lane_synced[i]),
      .sync_err      (lane_sync_error[i]),
      .demux_found   (lane_marker_demux_found[i]),
      .lane_map      (pcs_to_physical_lane_map[2*i +: 2]),
      .spacing_error (lane_marker_spacing_error[i]),
      .err_count     (sh_err_count[3*i +: 3]),
      .err_valid     (sh_err_valid[i])
    );
  end

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
      ((|(events & s.int_mask)) && !wr_en) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt output disagrees with masked status");

  property p_set_beats_clear;
    @(posedge pclk) disable iff (!presetn)
      (events[0] && w1c[0]) |=> s.int_stat[0];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("sync loss event lost under clear");

  property p_tick_period;
    @(posedge pclk) disable iff (!presetn)
      (s.tick && s.enable) |=> (!s.tick [*6]) ##1 (s.tick || !s.enable);
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("report tick period wrong");

endmodule

// ### dv/err_tally.sv
// user-side running totals of sync header error increments
`timescale 1ns/1ps
module err_tally (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // increments from the lane status block
  input  wire logic [11:0]  sh_err_count,
  input  wire logic [3:0]   sh_err_valid,
  // totals, lane i in bits [8i+7:8i]
  output logic [31:0]       totals,
  output logic              stray
);
  // add each qualified value, never load it as a total
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      totals <= '0;
      stray  <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (sh_err_valid[i] === 1'b1) begin
          totals[8*i +: 8] <= totals[8*i +: 8] + 8'(sh_err_count[3*i +: 3]);
        end else if (sh_err_count[3*i +: 3] !== 3'h0) begin
          stray <= 1'b1; // unqualified nonzero value
        end
      end
    end
  end
endmodule

// ### dv/test_rx_pcs_lane_sync_status.sv
// self-checking bench for the receive lane status block
`timescale 1ns/1ps
module test_rx_pcs_lane_sync_status;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hf;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        irq;
  logic [3:0]  word_valid = 4'h0;
  logic [3:0]  hdr_bad = 4'hf;
  logic [3:0]  marker_seen = 4'hf;
  logic [7:0]  marker_id = 8'h1b;
  logic [11:0] sh_err_count;
  logic [3:0]  sh_err_valid;
  logic [3:0]  lane_synced;
  logic [3:0]  lane_sync_error;
  logic [3:0]  lane_marker_demux_found;
  logic [7:0]  pcs_to_physical_lane_map;
  logic [3:0]  lane_marker_spacing_error;
  logic [31:0] totals;
  logic        stray;
  int          n_mismatch = 0;
  int          n_checks = 0;
  logic [31:0] q;
  logic        e;

  // clock and initial reset
  always #2 pclk = ~pclk;
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  end

  rx_pcs_lane_sync_status dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq),
    .word_valid(word_valid), .hdr_bad(hdr_bad),
    .marker_seen(marker_seen), .marker_id(marker_id),
    .sh_err_count(sh_err_count), .sh_err_valid(sh_err_valid),
    .lane_synced(lane_synced), .lane_sync_error(lane_sync_error),
    .lane_marker_demux_found(lane_marker_demux_found),
    .pcs_to_physical_lane_map(pcs_to_physical_lane_map),
    .lane_marker_spacing_error(lane_marker_spacing_error)
  );

  err_tally tally (
    .pclk(pclk), .presetn(presetn), .sh_err_count(sh_err_count),
    .sh_err_valid(sh_err_valid), .totals(totals), .stray(stray)
  );

  task automatic give_verdict;
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // n words on all lanes, marker pattern on the last one only;
  // idle cycles show junk on the qualified inputs on purpose
  task automatic words(input int n, input logic [3:0] bad,
                       input logic [3:0] mk);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      word_valid  <= 4'hf;
      hdr_bad     <= bad;
      marker_seen <= (i == n - 1) ? mk : 4'h0;
    end
    @(posedge pclk);
    word_valid  <= 4'h0;
    hdr_bad     <= 4'hf;
    marker_seen <= 4'hf;
    #1;
  endtask

  function automatic logic [31:0] levels();
    return {16'h0000, lane_synced, lane_sync_error,
            lane_marker_demux_found, lane_marker_spacing_error};
  endfunction

  task automatic t_regs;
    apb(0, lane_sync_pkg::ctrl_off, 0);
    chk("ctrl", 32'h0000_0001, q);
    apb(0, lane_sync_pkg::interval_off, 0);
    chk("interval", 32'h0000_3fff, q);
    apb(0, lane_sync_pkg::int_mask_off, 0);
    chk("mask", 32'h0000_0000, q);
    apb(0, 8'h18, 0);
    chk("unmapped", 32'h0000_0001, {q[30:0], e});
    apb(1, lane_sync_pkg::status_off, 32'hffff_ffff);
    apb(0, lane_sync_pkg::status_off, 0);
    chk("status ro", 32'h0000_0000, q);
    apb(1, lane_sync_pkg::interval_off, 32'h0000_0008);
    apb(0, lane_sync_pkg::interval_off, 0);
    chk("interval wr", 32'h0000_0008, q);
  endtask

  task automatic t_lock;
    words(64, 4'h0, 4'h0);
    chk("locked no marker", 32'h0000_0000, levels());
    words(1, 4'h0, 4'hf);
    chk("synced demux", 32'h0000_f0f0, levels());
    chk("map", 32'h0000_001b, pcs_to_physical_lane_map);
  endtask

  task automatic t_space;
    words(9, 4'h0, 4'hf);
    chk("spacing ok", 32'h0000_f0f0, levels());
    words(6, 4'h0, 4'hf);
    chk("spacing bad", 32'h0000_f0ff, levels());
    apb(0, lane_sync_pkg::int_stat_off, 0);
    chk("int stat", 32'h0000_00f0, {q[31:1], irq});
    apb(1, lane_sync_pkg::int_mask_off, 32'h0000_00f0);
    @(posedge pclk);
    #1;
    chk("irq on", 32'h0000_0001, irq);
    apb(1, lane_sync_pkg::int_stat_off, 32'h0000_00f0);
    @(posedge pclk);
    #1;
    chk("irq clear", 32'h0000_0000, irq);
    words(9, 4'h0, 4'hf);
    chk("spacing ends", 32'h0000_f0f0, levels());
  endtask

  task automatic t_loss;
    words(3, 4'h2, 4'h0);
    // clear lane 0 loss in the very cycle it is raised: the set must win
    fork
      words(16, 4'hf, 4'h0);
      begin
        repeat (15) @(posedge pclk);
        apb(1, lane_sync_pkg::int_stat_off, 32'h0000_0001);
      end
    join
    #1;
    chk("lock lost", 32'h0000_0f00, levels());
    repeat (20) @(posedge pclk);
    #1;
    chk("tallies", 32'h1010_1310, totals);
    chk("stray count", 32'h0000_0000, stray);
    apb(0, lane_sync_pkg::int_stat_off, 0);
    chk("loss event", 32'h0000_000f, q & 32'h0000_000f);
  endtask

  task automatic t_enable;
    apb(1, lane_sync_pkg::ctrl_off, 32'h0000_0000);
    @(posedge pclk);
    #1;
    chk("soft reset", 32'h0000_0000, levels());
    words(64, 4'h0, 4'h0);
    words(1, 4'h0, 4'hf);
    chk("disabled", 32'h0000_0000, levels());
    apb(1, lane_sync_pkg::ctrl_off, 32'h0000_0001);
  endtask

  task automatic t_reset;
    words(64, 4'h0, 4'h0);
    words(9, 4'h0, 4'h0);
    chk("no marker", 32'h0000_0f00, levels());
    words(1, 4'h0, 4'hf);
    @(posedge pclk);
    presetn <= 1'b0;
    #1;
    chk("reset levels", 32'h0000_0000, levels());
    chk("reset misc", 32'h0000_0000, {sh_err_valid, irq});
    @(posedge pclk);
    presetn <= 1'b1;
    apb(0, lane_sync_pkg::interval_off, 0);
    chk("interval again", 32'h0000_3fff, q);
  endtask

  // main sequence; outputs are checked while reset is held first
  initial begin
    // state is unknown until the first edge applies the held reset
    @(posedge pclk);
    #1;
    chk("in reset", 32'h0000_0000, levels());
    @(posedge presetn);
    t_regs();
    t_lock();
    t_space();
    t_loss();
    t_enable();
    t_reset();
    give_verdict();
  end

  // watchdog, well beyond the expected few hundred cycles
  initial begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    give_verdict();
  end
endmodule
